// File: design/dvsp_viewport.sv
// Viewport start address, stride and pixel pan logic for the LCD and CRT/TV paths
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "dvsp_regs.svh"

// Function
// - Start value is word address, zero first word
// - Start address sampled at every frame start
// - Pixel pan sampled at every line start
// - Status bit 7 reads one in blank
// - Below 15 bpp pan shifts sub-word
// - Start unit step is 16/bpp pixels
// - Word is two bytes, stride in words
// - Separate start settings for LCD, CRT/TV
// - Start split into bytes, bits 19-16 high
// - Eleven-bit word stride between displayed lines
// - Pan bits used per depth as LSBs
module dvsp_viewport import dvsp_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire dvsp_timing_type [1:0] timing_i,
    output dvsp_fetch_type [1:0] fetch_o,
    output logic irq_o
);
    dvsp_state_type state;
    dvsp_state_type next_state;
    logic req;
    logic wr;

    assign req = wb_cyc_i && wb_stb_i && (state.bus == DVSP_IDLE);
    assign wr = req && wb_we_i && wb_sel_i[0];

    // Byte offset of a path register; path 0 is LCD, path 1 is CRT/TV
    function automatic logic [7:0] base_of(input int p, input logic [7:0] lcd, input logic [7:0] tv);
        base_of = (p == 0) ? lcd : tv;
    endfunction

    // Pan bits that count at the path's colour depth
    function automatic logic [1:0] pan_used(input logic [1:0] bpp, input logic [1:0] pan);
        unique case (bpp)
            `DVSP_BPP_4: pan_used = pan;
            `DVSP_BPP_8: pan_used = {1'b0, pan[0]};
            default: pan_used = 2'h0;
        endcase
    endfunction

    // Next-state logic: bus slave, staging, sampling and interrupts
    always_comb begin
        next_state = state;
        next_state.bus = DVSP_IDLE;
        if (req) begin
            next_state.bus = DVSP_ACK;
        end
        next_state.rdata = 32'h00000000;
        for (int p = 0; p < 2; p++) begin
            next_state.path[p].blank_q = timing_i[p].vblank;
            // Blank entry raises a sticky event; set wins over clear
            if (wr && wb_adr_i == `DVSP_IRQ_STATUS && wb_dat_i[p]) begin
                next_state.irq_status[p] = 1'b0;
            end
            if (timing_i[p].vblank && !state.path[p].blank_q) begin
                next_state.irq_status[p] = 1'b1;
            end
            if (wr) begin
                // Start and pan writes land in staging, stride writes go live at once; whole address swaps later
                if (wb_adr_i == base_of(p, `DVSP_LCD_START_LOW, `DVSP_TV_START_LOW)) begin
                    next_state.path[p].start_stage[7:0] = wb_dat_i[7:0];
                end
                if (wb_adr_i == base_of(p, `DVSP_LCD_START_MID, `DVSP_TV_START_MID)) begin
                    next_state.path[p].start_stage[15:8] = wb_dat_i[7:0];
                end
                if (wb_adr_i == base_of(p, `DVSP_LCD_START_HIGH, `DVSP_TV_START_HIGH)) begin
                    next_state.path[p].start_stage[19:16] = wb_dat_i[3:0];
                end
                if (wb_adr_i == base_of(p, `DVSP_LCD_STRIDE_LOW, `DVSP_TV_STRIDE_LOW)) begin
                    next_state.path[p].stride[7:0] = wb_dat_i[7:0];
                end
                if (wb_adr_i == base_of(p, `DVSP_LCD_STRIDE_HIGH, `DVSP_TV_STRIDE_HIGH)) begin
                    next_state.path[p].stride[10:8] = wb_dat_i[2:0];
                end
                if (wb_adr_i == base_of(p, `DVSP_LCD_PAN, `DVSP_TV_PAN)) begin
                    next_state.path[p].pan_stage = wb_dat_i[1:0];
                end
            end
            // Frame start latches the start and restarts the line walk
            if (timing_i[p].frame_start) begin
                next_state.path[p].start_active = state.path[p].start_stage;
                next_state.path[p].line_addr = {1'b0, state.path[p].start_stage};
                next_state.path[p].pan_active = pan_used(timing_i[p].bpp, state.path[p].pan_stage);
            end else if (timing_i[p].line_start) begin
                next_state.path[p].line_addr = state.path[p].line_addr
                    + {10'h000, state.path[p].stride};
                next_state.path[p].pan_active = pan_used(timing_i[p].bpp, state.path[p].pan_stage);
            end
            // Read mux
            if (wb_adr_i == base_of(p, `DVSP_LCD_START_LOW, `DVSP_TV_START_LOW)) begin
                next_state.rdata = {24'h000000, state.path[p].start_stage[7:0]};
            end
            if (wb_adr_i == base_of(p, `DVSP_LCD_START_MID, `DVSP_TV_START_MID)) begin
                next_state.rdata = {24'h000000, state.path[p].start_stage[15:8]};
            end
            if (wb_adr_i == base_of(p, `DVSP_LCD_START_HIGH, `DVSP_TV_START_HIGH)) begin
                next_state.rdata = {28'h0000000, state.path[p].start_stage[19:16]};
            end
            if (wb_adr_i == base_of(p, `DVSP_LCD_STRIDE_LOW, `DVSP_TV_STRIDE_LOW)) begin
                next_state.rdata = {24'h000000, state.path[p].stride[7:0]};
            end
            if (wb_adr_i == base_of(p, `DVSP_LCD_STRIDE_HIGH, `DVSP_TV_STRIDE_HIGH)) begin
                next_state.rdata = {29'h00000000, state.path[p].stride[10:8]};
            end
            if (wb_adr_i == base_of(p, `DVSP_LCD_PAN, `DVSP_TV_PAN)) begin
                next_state.rdata = {30'h00000000, state.path[p].pan_stage};
            end
            if (wb_adr_i == base_of(p, `DVSP_LCD_STATUS, `DVSP_TV_STATUS)) begin
                next_state.rdata = {24'h000000, timing_i[p].vblank, 7'h00};
            end
        end
        if (wr && wb_adr_i == `DVSP_IRQ_MASK) begin
            next_state.irq_mask = wb_dat_i[1:0];
        end
        if (wb_adr_i == `DVSP_IRQ_STATUS) begin
            next_state.rdata = {30'h00000000, state.irq_status};
        end
        if (wb_adr_i == `DVSP_IRQ_MASK) begin
            next_state.rdata = {30'h00000000, state.irq_mask};
        end
        if (!req) begin
            next_state.rdata = state.rdata;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '0;
            // Blank detectors start at the idle level, so reset raises no false event
            state.path[0].blank_q <= 1'b1;
            state.path[1].blank_q <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign wb_ack_o = (state.bus == DVSP_ACK);
    assign wb_dat_o = state.rdata;
    assign irq_o = |(state.irq_status & state.irq_mask);
    assign fetch_o[0] = '{line_addr: state.path[0].line_addr, pixel_skip: state.path[0].pan_active};
    assign fetch_o[1] = '{line_addr: state.path[1].line_addr, pixel_skip: state.path[1].pan_active};

    // Checks
    property p_frame_latch;
        @(posedge clk_i) disable iff (rst_i)
        timing_i[0].frame_start |=> fetch_o[0].line_addr == {1'b0, $past(state.path[0].start_stage)};
    endproperty
    a_frame_latch: assert property (p_frame_latch) else $error("start not latched at frame");

    property p_hold_frame;
        @(posedge clk_i) disable iff (rst_i)
        !timing_i[1].frame_start |=> state.path[1].start_active == $past(state.path[1].start_active);
    endproperty
    a_hold_frame: assert property (p_hold_frame) else $error("start changed mid frame");

    property p_line_step;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[0].line_start && !timing_i[0].frame_start) |=>
            fetch_o[0].line_addr == $past(state.path[0].line_addr) + {10'h000, $past(state.path[0].stride)};
    endproperty
    a_line_step: assert property (p_line_step) else $error("line stride step wrong");

    property p_pan16;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[0].line_start && timing_i[0].bpp[1]) |=> fetch_o[0].pixel_skip == 2'h0;
    endproperty
    a_pan16: assert property (p_pan16) else $error("pan used at high depth");

    property p_pan4;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[1].line_start && timing_i[1].bpp == `DVSP_BPP_4) |=>
            fetch_o[1].pixel_skip == $past(state.path[1].pan_stage);
    endproperty
    a_pan4: assert property (p_pan4) else $error("pan not sampled at line");

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == `DVSP_LCD_STATUS;
    endsequence
    property p_status;
        @(posedge clk_i) disable iff (rst_i)
        s_req |=> wb_ack_o && wb_dat_o[`DVSP_BLANK_BIT] == $past(timing_i[0].vblank);
    endproperty
    a_status: assert property (p_status) else $error("blank status wrong");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[1].vblank && !state.path[1].blank_q) |=> state.irq_status[1];
    endproperty
    a_irq: assert property (p_irq) else $error("blank event lost");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held two cycles");

    // Further checks on both paths and the bus
    property p_frame_latch_tv;
        @(posedge clk_i) disable iff (rst_i)
        timing_i[1].frame_start |=> fetch_o[1].line_addr == {1'b0, $past(state.path[1].start_stage)};
    endproperty
    a_frame_latch_tv: assert property (p_frame_latch_tv) else $error("tv start not latched");

    property p_hold_frame_lcd;
        @(posedge clk_i) disable iff (rst_i)
        !timing_i[0].frame_start |=> state.path[0].start_active == $past(state.path[0].start_active);
    endproperty
    a_hold_frame_lcd: assert property (p_hold_frame_lcd) else $error("lcd start changed mid frame");

    property p_line_step_tv;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[1].line_start && !timing_i[1].frame_start) |=>
            fetch_o[1].line_addr == $past(state.path[1].line_addr) + {10'h000, $past(state.path[1].stride)};
    endproperty
    a_line_step_tv: assert property (p_line_step_tv) else $error("tv stride step wrong");

    property p_pan4_lcd;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[0].line_start && timing_i[0].bpp == `DVSP_BPP_4) |=>
            fetch_o[0].pixel_skip == $past(state.path[0].pan_stage);
    endproperty
    a_pan4_lcd: assert property (p_pan4_lcd) else $error("lcd pan not sampled");

    property p_pan8_lcd;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[0].line_start && timing_i[0].bpp == `DVSP_BPP_8) |=>
            fetch_o[0].pixel_skip == {1'b0, $past(state.path[0].pan_stage[0])};
    endproperty
    a_pan8_lcd: assert property (p_pan8_lcd) else $error("lcd pan mask wrong");

    property p_pan8_tv;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[1].line_start && timing_i[1].bpp == `DVSP_BPP_8) |=>
            fetch_o[1].pixel_skip == {1'b0, $past(state.path[1].pan_stage[0])};
    endproperty
    a_pan8_tv: assert property (p_pan8_tv) else $error("tv pan mask wrong");

    property p_pan16_tv;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[1].line_start && timing_i[1].bpp[1]) |=> fetch_o[1].pixel_skip == 2'h0;
    endproperty
    a_pan16_tv: assert property (p_pan16_tv) else $error("tv pan used at high depth");

    sequence s_wr_low;
        wr && wb_adr_i == `DVSP_LCD_START_LOW;
    endsequence
    property p_start_low;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_low |=> state.path[0].start_stage[7:0] == $past(wb_dat_i[7:0]);
    endproperty
    a_start_low: assert property (p_start_low) else $error("start low byte not staged");

    sequence s_wr_high;
        wr && wb_adr_i == `DVSP_LCD_START_HIGH;
    endsequence
    property p_start_high;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_high |=> state.path[0].start_stage[19:16] == $past(wb_dat_i[3:0]);
    endproperty
    a_start_high: assert property (p_start_high) else $error("start high bits not staged");

    sequence s_wr_tv_low;
        wr && wb_adr_i == `DVSP_TV_START_LOW;
    endsequence
    property p_tv_apart;
        @(posedge clk_i) disable iff (rst_i)
        s_wr_tv_low |=> state.path[0].start_stage == $past(state.path[0].start_stage);
    endproperty
    a_tv_apart: assert property (p_tv_apart) else $error("tv write touched lcd start");

    sequence s_req_tv;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == `DVSP_TV_STATUS;
    endsequence
    property p_status_tv;
        @(posedge clk_i) disable iff (rst_i)
        s_req_tv |=> wb_ack_o && wb_dat_o[`DVSP_BLANK_BIT] == $past(timing_i[1].vblank);
    endproperty
    a_status_tv: assert property (p_status_tv) else $error("tv blank status wrong");

    property p_irq_lcd;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[0].vblank && !state.path[0].blank_q) |=> state.irq_status[0];
    endproperty
    a_irq_lcd: assert property (p_irq_lcd) else $error("lcd blank event lost");

    property p_irq_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == `DVSP_IRQ_STATUS && wb_dat_i[0] && !(timing_i[0].vblank && !state.path[0].blank_q))
            |=> !state.irq_status[0];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

    property p_no_ack;
        @(posedge clk_i) disable iff (rst_i)
        !req |=> !wb_ack_o;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack without request");

    property p_rd_hold;
        @(posedge clk_i) disable iff (rst_i)
        !req |=> $stable(wb_dat_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without request");

    property p_stride_high;
        @(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == `DVSP_LCD_STRIDE_HIGH) |=> state.path[0].stride[10:8] == $past(wb_dat_i[2:0]);
    endproperty
    a_stride_high: assert property (p_stride_high) else $error("stride high bits not stored");

    property p_stride_low;
        @(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == `DVSP_TV_STRIDE_LOW) |=> state.path[1].stride[7:0] == $past(wb_dat_i[7:0]);
    endproperty
    a_stride_low: assert property (p_stride_low) else $error("stride low byte not stored");

    property p_frame_zero;
        @(posedge clk_i) disable iff (rst_i)
        (timing_i[0].frame_start && state.path[0].start_stage == `DVSP_START_RESET) |=> fetch_o[0].line_addr == 21'h000000;
    endproperty
    a_frame_zero: assert property (p_frame_zero) else $error("zero start not first word");
endmodule

// File: design/dvsp_regs.svh
// Register offsets, field positions and reset values of the viewport start and pan block
`ifndef DVSP_REGS_SVH
`define DVSP_REGS_SVH
`define DVSP_LCD_START_LOW 8'h42
`define DVSP_LCD_START_MID 8'h43
`define DVSP_LCD_START_HIGH 8'h44
`define DVSP_LCD_STRIDE_LOW 8'h46
`define DVSP_LCD_STRIDE_HIGH 8'h47
`define DVSP_LCD_PAN 8'h48
`define DVSP_LCD_STATUS 8'h3A
`define DVSP_TV_START_LOW 8'h62
`define DVSP_TV_START_MID 8'h63
`define DVSP_TV_START_HIGH 8'h64
`define DVSP_TV_STRIDE_LOW 8'h66
`define DVSP_TV_STRIDE_HIGH 8'h67
`define DVSP_TV_PAN 8'h68
`define DVSP_TV_STATUS 8'h58
`define DVSP_IRQ_STATUS 8'h70
`define DVSP_IRQ_MASK 8'h71
`define DVSP_BLANK_BIT 7
`define DVSP_WORD_BITS 5'h10
`define DVSP_START_RESET 20'h00000
`define DVSP_STRIDE_RESET 11'h000
`define DVSP_BPP_4 2'h0
`define DVSP_BPP_8 2'h1
`define DVSP_BPP_15 2'h2
`define DVSP_BPP_16 2'h3
`endif

// File: design/dvsp_pkg.sv
// Types of the viewport start and pan block
package dvsp_pkg;
    typedef enum logic [1:0] {DVSP_IDLE, DVSP_ACK} dvsp_bus_type;

    // Per-path register and active copies
    typedef struct packed {
        logic [19:0] start_stage;
        logic [10:0] stride;
        logic [1:0] pan_stage;
        logic [19:0] start_active;
        logic [1:0] pan_active;
        logic [20:0] line_addr;
        logic blank_q;
    } dvsp_path_type;

    typedef struct packed {
        dvsp_path_type [1:0] path;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        dvsp_bus_type bus;
        logic [31:0] rdata;
    } dvsp_state_type;

    // Timing inputs and fetch outputs of one display path
    typedef struct packed {
        logic frame_start;
        logic line_start;
        logic vblank;
        logic [1:0] bpp;
    } dvsp_timing_type;

    typedef struct packed {
        logic [20:0] line_addr;
        logic [1:0] pixel_skip;
    } dvsp_fetch_type;
endpackage

// File: dv/dvsp_timer.sv
// Display timing source that stands in for one path's frame and line generator
`timescale 1ns/1ps
module dvsp_timer import dvsp_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [1:0] bpp_i,
    output dvsp_timing_type tim_o
);
    logic run;
    logic [3:0] cnt;

    // One short frame per go pulse, blank while idle
    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            run <= go_i && !rst_i;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
            run <= (cnt != 4'hF);
        end
    end

    // Frame start at count 0, two more lines, blank from count 12
    always_comb begin
        tim_o.frame_start = run && (cnt == 4'h0);
        tim_o.line_start = run && (cnt == 4'h4 || cnt == 4'h8);
        tim_o.vblank = !run || (cnt >= 4'hC);
        tim_o.bpp = bpp_i;
    end
endmodule

// File: dv/tb.sv
// Self-checking testbench of the viewport start and pan block
`timescale 1ns/1ps
module tb import dvsp_pkg::*;;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
    logic [7:0] adr = 8'h00, q;
    logic [31:0] wdat = 32'h0, rdat;
    logic [1:0] go = 2'h0;
    logic [1:0][1:0] bpp = 4'h0;
    wire dvsp_timing_type [1:0] tim;
    dvsp_fetch_type [1:0] fet;
    int error_cnt = 0, n_tests = 0;

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    dvsp_viewport uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timing_i(tim), .fetch_o(fet), .irq_o(irq));
    dvsp_timer lcd (.clk_i(clk), .rst_i(rst), .go_i(go[0]), .bpp_i(bpp[0]), .tim_o(tim[0]));
    dvsp_timer tv (.clk_i(clk), .rst_i(rst), .go_i(go[1]), .bpp_i(bpp[1]), .tim_o(tim[1]));

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string n, input logic [20:0] s, input logic [20:0] e);
        n_tests++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            results;
        end
        r = rdat[7:0];
        cyc <= 0;
        stb <= 0;
    endtask

    // Wait for blank, then start bytes, stride, pan last
    task automatic set_view(input int p, input logic [19:0] st, input logic [10:0] sd, input logic [1:0] pan);
        logic [7:0] b = p ? 8'h62 : 8'h42;
        int n = 0;
        do begin
            wb(0, p ? 8'h58 : 8'h3A, 8'h00, q);
            n++;
        end while (q[7] !== 1'b1 && n < 20);
        chk("blank_status", 21'(q[7]), 21'h1);
        wb(1, b, st[7:0], q);
        wb(1, b + 8'h1, st[15:8], q);
        wb(1, b + 8'h2, {4'h0, st[19:16]}, q);
        wb(1, b + 8'h4, sd[7:0], q);
        wb(1, b + 8'h5, {5'h0, sd[10:8]}, q);
        wb(1, b + 8'h6, {6'h0, pan}, q);
    endtask

    // One frame of three lines; optional start write in mid-frame
    task automatic frame(input int p, input logic [20:0] st, input logic [10:0] sd, input logic [1:0] pe, input bit mid);
        int n = 0;
        // Let the timer finish its previous frame so the go pulse is seen
        repeat (4) @(posedge clk);
        @(posedge clk) go[p] <= 1;
        @(posedge clk) go[p] <= 0;
        repeat (2) @(posedge clk);
        chk("line_addr", fet[p].line_addr, st);
        chk("pixel_skip", 21'(fet[p].pixel_skip), 21'(pe));
        wb(0, p ? 8'h58 : 8'h3A, 8'h00, q);
        chk("active_status", 21'(q[7]), 21'h0);
        if (mid) wb(1, p ? 8'h62 : 8'h42, 8'h55, q);
        do begin
            @(posedge clk);
            n++;
        end while (tim[p].vblank !== 1'b1 && n < 40);
        chk("last_line", fet[p].line_addr, st + 21'(sd) * 21'h2);
    endtask

    task t_regs;
        foreach (q[i]) if (i < 4) begin
            wb(0, i[1] ? 8'h62 + 8'(i[0]) : 8'h42 + 8'(i[0]), 8'h00, q);
            chk("start_reset", 21'(q), 21'h0);
        end
        wb(1, 8'h44, 8'hFF, q);
        wb(0, 8'h44, 8'h00, q);
        chk("start_high", 21'(q), 21'h0F);
        wb(1, 8'h62, 8'hA5, q);
        wb(0, 8'h42, 8'h00, q);
        chk("lcd_low", 21'(q), 21'h0);
        wb(1, 8'h10, 8'h3C, q);
        wb(0, 8'h10, 8'h00, q);
        chk("unmapped", 21'(q), 21'h0);
        $display("test regs done");
    endtask

    task t_depth;
        for (int b = 0; b < 4; b++) begin
            bpp[0] <= 2'(b);
            set_view(0, 20'hFFFFF - 20'(b), 11'h7FF, 2'h3);
            frame(0, 21'h0FFFFF - 21'(b), 11'h7FF, b == 0 ? 2'h3 : (b == 1 ? 2'h1 : 2'h0), 0);
        end
        $display("test depth done");
    endtask

    task t_stage;
        bpp[1] <= 2'h1;
        set_view(1, 20'h12345, 11'h190, 2'h1);
        frame(1, 21'h12345, 11'h190, 2'h1, 1);
        frame(1, 21'h12355, 11'h190, 2'h1, 0);
        $display("test stage done");
    endtask

    task t_irq;
        wb(1, 8'h71, 8'h00, q);
        wb(1, 8'h70, 8'h03, q);
        wb(1, 8'h71, 8'h01, q);
        frame(1, 21'h12355, 11'h190, 2'h1, 0);
        repeat (3) @(posedge clk);
        chk("irq_masked", 21'(irq), 21'h0);
        wb(0, 8'h70, 8'h00, q);
        chk("irq_status", 21'(q), 21'h2);
        frame(0, 21'h0FFFFC, 11'h7FF, 2'h0, 0);
        repeat (3) @(posedge clk);
        chk("irq_raised", 21'(irq), 21'h1);
        wb(1, 8'h70, 8'h01, q);
        repeat (2) @(posedge clk);
        chk("irq_cleared", 21'(irq), 21'h0);
        $display("test irq done");
    endtask

    // Reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        t_regs;
        t_depth;
        t_stage;
        t_irq;
        results;
    end
endmodule
